// ===== verilog/ptw_walker.sv
// translation table walker with descriptor decode, abort reporting and ahb-lite registers
//
// Summary of operation
// - pick first-level address from one of two bases
// - read first-level descriptor from external memory
// - first-level type: fault, table, section, reserved-fault
// - first-level fault gives prefetch or data abort
// - table pointer triggers second-level descriptor read
// - physical address used only after permission checks
// - second-level type zero is translation fault
// - second-level type one is 64KB page
// - legacy: type two small, three extended small
// - extended: bit1 set is extended small, bit0 execute-never
// - legacy large page splits into 16KB subpages
// - legacy small page splits into 1KB subpages
// - legacy extended small splits into 1KB subpages
// - format select: zero legacy, one extended
// - selector N picks base by top VA bits
// - descriptor bit 18 marks 16MB supersection
`timescale 1ns/1ns
`include "ptw_regs.svh"
module ptw_walker (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic             req_valid,
  input  wire ptw_pkg::ptw_req_t req,
  output logic                  req_ready,
  output logic                  mem_rd_valid,
  output logic [31:0]           mem_addr,
  input  wire logic             mem_rvalid,
  input  wire logic [31:0]      mem_rdata,
  output logic                  rsp_valid,
  output ptw_pkg::ptw_rsp_t     rsp,
  input  wire logic             chk_done,
  input  wire logic             chk_ok,
  output logic                  xfer_valid,
  output logic [31:0]           xfer_pa,
  output logic                  abort_prefetch,
  output logic                  abort_data,
  output logic                  irq
);
  import ptw_pkg::*;

  // first-level descriptor address for the chosen base
  function automatic logic [31:0] l1_addr(input logic [31:0] base, input logic [31:0] va, input logic [2:0] n);
    logic [31:0] keep;
    keep = `PTW_L1_BASE_MASK >> n;
    l1_addr = (base & ~keep) | ((va >> 18) & keep & 32'hFFFF_FFFC);
  endfunction

  // four permission pairs in bits 11:4, pair 0 lowest
  function automatic logic [1:0] ap_pick(input logic [31:0] d, input logic [1:0] sel);
    ap_pick = d[4 + 2 * sel +: 2];
  endfunction

  function automatic logic ap_same(input logic [31:0] d);
    ap_same = (d[11:10] == d[9:8]) && (d[9:8] == d[7:6]) && (d[7:6] == d[5:4]);
  endfunction

  ptw_state_t  state_q;
  logic [31:0] ctrl_q;
  logic [31:0] proc_base_q;
  logic [31:0] sys_base_q;
  logic [31:0] mask_q;
  logic [`PTW_ST_W-1:0] status_q;
  logic [31:0] va_q;
  logic        instr_q;
  logic [31:0] mem_addr_q;
  ptw_rsp_t    rsp_q;
  logic [31:0] hrdata_q;
  logic        wr_pend_q;
  logic [7:0]  wr_off_q;

  // control fields
  wire [2:0] sel_n    = ctrl_q[`PTW_CTRL_SEL_MSB:`PTW_CTRL_SEL_LSB];
  wire       fmt_ext  = ctrl_q[`PTW_CTRL_FMT_BIT];
  // base choice: N zero always process base, else top N bits must be zero
  wire [31:0] top_mask = ~(32'hFFFF_FFFF >> sel_n);
  wire        use_proc = (sel_n == 3'h0) || ((req.va & top_mask) == 32'h0000_0000);
  wire [31:0] l1_addr_w = use_proc ? l1_addr(proc_base_q, req.va, sel_n)
                                   : l1_addr(sys_base_q, req.va, 3'h0);

  // first-level decode of the returned word
  wire [1:0]  t1       = mem_rdata[1:0];
  wire        l1_fault = (t1 == `PTW_TYPE_FAULT) || (t1 == `PTW_TYPE_RSVD);
  wire        l1_table = (t1 == `PTW_TYPE_TABLE);
  wire        l1_super = mem_rdata[`PTW_SUPER_BIT];
  wire [31:0] l2_addr_w = {mem_rdata[31:10], va_q[19:12], 2'b00};
  wire [31:0] sec_pa   = l1_super ? {mem_rdata[31:24], va_q[23:0]}
                                  : {mem_rdata[31:20], va_q[19:0]};

  // second-level decode; extended small is type three in legacy format, any bit1-set type in extended format
  wire [1:0]  t2       = mem_rdata[1:0];
  wire        l2_fault = (t2 == 2'h0);
  wire        l2_large = (t2 == 2'h1);
  wire        l2_ext   = fmt_ext ? t2[1] : (t2 == 2'h3);
  wire        l2_sub   = !fmt_ext && !ap_same(mem_rdata) && !l2_fault;
  wire [1:0]  sub_sel  = l2_large ? va_q[15:14] : va_q[11:10];
  wire [1:0]  l2_ap    = fmt_ext ? mem_rdata[5:4] : ap_pick(mem_rdata, sub_sel);
  wire        l2_xn    = fmt_ext && (l2_large ? mem_rdata[15] : mem_rdata[0]);
  wire [31:0] l2_pa    = l2_large ? {mem_rdata[31:16], va_q[15:0]} : {mem_rdata[31:12], va_q[11:0]};
  wire ptw_size_t l2_size = l2_large ? PTW_SZ_LARGE : (l2_ext ? PTW_SZ_EXT : PTW_SZ_SMALL);

  wire l1_ack  = (state_q == PTW_L1_RD) && mem_rvalid;
  wire l2_ack  = (state_q == PTW_L2_RD) && mem_rvalid;
  wire resp_end = (state_q == PTW_RESP) && (rsp_q.fault || chk_done);

  // walk sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q    <= PTW_IDLE;
      va_q       <= 32'h0000_0000;
      instr_q    <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      rsp_q      <= '0;
    end
    else if (ce)
    begin
      case (state_q)
        PTW_IDLE:
        begin
          if (req_valid)
          begin
            va_q       <= req.va;
            instr_q    <= req.instr;
            mem_addr_q <= l1_addr_w;
            state_q    <= PTW_L1_RD;
          end
        end
        PTW_L1_RD:
        begin
          if (mem_rvalid)
          begin
            rsp_q.instr <= instr_q;
            if (l1_table)
            begin
              mem_addr_q <= l2_addr_w;
              state_q    <= PTW_L2_RD;
            end
            else
            begin
              rsp_q.fault    <= l1_fault;
              rsp_q.pa       <= sec_pa;
              rsp_q.size     <= l1_super ? PTW_SZ_SUPER : PTW_SZ_SECTION;
              rsp_q.access_permission_pair <= mem_rdata[11:10];
              rsp_q.execute_never_flag     <= fmt_ext && mem_rdata[4];
              rsp_q.subpage  <= 1'b0;
              state_q        <= PTW_RESP;
            end
          end
        end
        PTW_L2_RD:
        begin
          if (mem_rvalid)
          begin
            rsp_q.fault    <= l2_fault;
            rsp_q.pa       <= l2_pa;
            rsp_q.size     <= l2_size;
            rsp_q.access_permission_pair <= l2_ap;
            rsp_q.execute_never_flag     <= l2_xn;
            rsp_q.subpage  <= l2_sub;
            state_q        <= PTW_RESP;
          end
        end
        PTW_RESP:
        begin
          if (resp_end)
            state_q <= PTW_IDLE;
        end
        default:
          state_q <= PTW_IDLE;
      endcase
    end
  end

  // handshakes and results; transfer address waits for the checker verdict
  assign req_ready      = (state_q == PTW_IDLE);
  assign mem_rd_valid   = (state_q == PTW_L1_RD) || (state_q == PTW_L2_RD);
  assign mem_addr       = mem_addr_q;
  assign rsp_valid      = (state_q == PTW_RESP);
  assign rsp            = rsp_q;
  assign xfer_valid     = rsp_valid && !rsp_q.fault && chk_done && chk_ok;
  assign xfer_pa        = rsp_q.pa;
  assign abort_prefetch = rsp_valid && rsp_q.fault && rsp_q.instr;
  assign abort_data     = rsp_valid && rsp_q.fault && !rsp_q.instr;

  // ahb-lite address phase decode; always zero wait, always okay
  wire       ahb_go = hsel && htrans[1] && hready;
  wire [7:0] ahb_off = haddr[7:0];
  wire       wr_ctrl = wr_pend_q && (wr_off_q == `PTW_OFF_CTRL);
  wire       wr_pb   = wr_pend_q && (wr_off_q == `PTW_OFF_PROC_BASE);
  wire       wr_sb   = wr_pend_q && (wr_off_q == `PTW_OFF_SYS_BASE);
  wire       wr_st   = wr_pend_q && (wr_off_q == `PTW_OFF_STATUS);
  wire       wr_mk   = wr_pend_q && (wr_off_q == `PTW_OFF_MASK);
  wire [31:0] rd_mux =
    (ahb_off == `PTW_OFF_CTRL)      ? ctrl_q :
    (ahb_off == `PTW_OFF_PROC_BASE) ? proc_base_q :
    (ahb_off == `PTW_OFF_SYS_BASE)  ? sys_base_q :
    (ahb_off == `PTW_OFF_STATUS)    ? {29'h0, status_q} :
    (ahb_off == `PTW_OFF_MASK)      ? mask_q :
    (ahb_off == `PTW_OFF_LAST_PA)   ? rsp_q.pa : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // completion events; a set in the clearing cycle wins
  wire [`PTW_ST_W-1:0] ev = {abort_data && resp_end, abort_prefetch && resp_end, resp_end};
  wire [`PTW_ST_W-1:0] st_clr = wr_st ? hwdata[`PTW_ST_W-1:0] : 3'h0;
  assign irq = |(status_q & mask_q[`PTW_ST_W-1:0]);

  // register file; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q      <= `PTW_CTRL_RESET;
      proc_base_q <= `PTW_BASE_RESET;
      sys_base_q  <= `PTW_BASE_RESET;
      mask_q      <= 32'h0000_0000;
      status_q    <= 3'h0;
      wr_pend_q   <= 1'b0;
      wr_off_q    <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wr_pend_q <= ahb_go && hwrite;
      wr_off_q  <= ahb_off;
      if (ahb_go && !hwrite)
        hrdata_q <= rd_mux;
      if (wr_ctrl)
        ctrl_q <= hwdata;
      if (wr_pb)
        proc_base_q <= hwdata;
      if (wr_sb)
        sys_base_q <= hwdata;
      if (wr_mk)
        mask_q <= hwdata;
      status_q <= (status_q & ~st_clr) | ev;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  l1_fetch_addr_a: assert property (ce && state_q == PTW_IDLE && req_valid |=>
    state_q == PTW_L1_RD && mem_rd_valid && mem_addr == $past(l1_addr_w))
    else $error("first-level address not issued");

  l1_fault_dec_a: assert property (ce && l1_ack && (t1 == 2'h0 || t1 == 2'h3) |=>
    rsp_valid && rsp.fault)
    else $error("reserved or zero descriptor not a fault");

  abort_kind_a: assert property (ce && l1_ack && l1_fault && instr_q |=>
    abort_prefetch && !abort_data)
    else $error("instruction fault not a prefetch abort");

  l2_walk_a: assert property (ce && l1_ack && t1 == 2'h1 |=>
    state_q == PTW_L2_RD && mem_addr[9:2] == va_q[19:12] && mem_addr[31:10] == $past(mem_rdata[31:10]))
    else $error("second-level fetch wrong");

  xfer_gate_a: assert property (xfer_valid |-> chk_done && chk_ok && !rsp.fault)
    else $error("transfer before checks");

  l2_fault_a: assert property (ce && l2_ack && t2 == 2'h0 |=>
    rsp.fault && (abort_data != abort_prefetch))
    else $error("second-level zero not a fault");

  ext_small_a: assert property (ce && l2_ack && fmt_ext && t2[1] |=>
    rsp.size == PTW_SZ_EXT && rsp.execute_never_flag == $past(mem_rdata[0]) && !rsp.subpage)
    else $error("extended small page decode wrong");

  sec_pa_a: assert property (ce && l1_ack && t1 == 2'h2 && !mem_rdata[18] |=>
    rsp.pa[19:0] == va_q[19:0] && rsp.size == PTW_SZ_SECTION)
    else $error("section address wrong");

  large_sub_a: assert property (ce && l2_ack && !fmt_ext && t2 == 2'h1 && !ap_same(mem_rdata) |=>
    rsp.subpage && rsp.access_permission_pair == ap_pick($past(mem_rdata), va_q[15:14]))
    else $error("large subpage permission wrong");

  small_sub_a: assert property (ce && l2_ack && !fmt_ext && t2 == 2'h2 && !ap_same(mem_rdata) |=>
    rsp.subpage && rsp.size == PTW_SZ_SMALL && rsp.access_permission_pair == ap_pick($past(mem_rdata), va_q[11:10]))
    else $error("small subpage permission wrong");

  // a va with any of its top n bits set must walk from the system base
  sys_base_a: assert property (ce && state_q == PTW_IDLE && req_valid && sel_n != 3'h0 &&
    (req.va & top_mask) != 32'h0000_0000 |=> mem_addr[31:14] == $past(sys_base_q[31:14]))
    else $error("system base not chosen");

  irq_level_a: assert property (ce && resp_end && mask_q[0] |=> irq)
    else $error("done interrupt missing");
endmodule

// ===== pkg/ptw_regs.svh
// register offsets, field positions, reset values and codes for the table walker
`ifndef PTW_REGS_SVH
`define PTW_REGS_SVH
`define PTW_OFF_CTRL      8'h00
`define PTW_OFF_PROC_BASE 8'h04
`define PTW_OFF_SYS_BASE  8'h08
`define PTW_OFF_STATUS    8'h0C
`define PTW_OFF_MASK      8'h10
`define PTW_OFF_LAST_PA   8'h14
`define PTW_CTRL_SEL_LSB  0
`define PTW_CTRL_SEL_MSB  2
`define PTW_CTRL_FMT_BIT  23
`define PTW_CTRL_RESET    32'h0000_0000
`define PTW_BASE_RESET    32'h0000_0000
`define PTW_ST_DONE       0
`define PTW_ST_PABT       1
`define PTW_ST_DABT       2
`define PTW_ST_W          3
`define PTW_L1_BASE_MASK  32'h0000_3FFF
`define PTW_SUPER_BIT     18
`define PTW_TYPE_FAULT    2'h0
`define PTW_TYPE_TABLE    2'h1
`define PTW_TYPE_SECTION  2'h2
`define PTW_TYPE_RSVD     2'h3
`endif

// ===== pkg/ptw_pkg.sv
// types shared by the table walker and its users
package ptw_pkg;
  typedef enum logic [2:0] {
    PTW_SZ_SECTION = 3'h0,
    PTW_SZ_SUPER   = 3'h1,
    PTW_SZ_LARGE   = 3'h2,
    PTW_SZ_SMALL   = 3'h3,
    PTW_SZ_EXT     = 3'h4
  } ptw_size_t;
  typedef enum logic [1:0] {
    PTW_IDLE  = 2'b00,
    PTW_L1_RD = 2'b01,
    PTW_L2_RD = 2'b10,
    PTW_RESP  = 2'b11
  } ptw_state_t;
  typedef struct packed {
    logic [31:0] va;
    logic        instr;
  } ptw_req_t;
  typedef struct packed {
    logic [31:0] pa;
    ptw_size_t   size;
    logic [1:0]  access_permission_pair;
    logic        execute_never_flag;
    logic        subpage;
    logic        fault;
    logic        instr;
  } ptw_rsp_t;
endpackage

// ===== bench/ptw_mem_model.sv
// behavioural table memory answering descriptor reads after a chosen delay
`timescale 1ns/1ns
module ptw_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_rd_valid,
  input  wire logic [31:0] mem_addr,
  input  wire logic [1:0]  lat,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata
);
  bit   [31:0] words [bit [31:0]];
  logic [1:0]  cnt_q;
  // idle data lines toggle so a stale word never passes for a fresh one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h5A5A_A5A5;
      cnt_q      <= 2'h0;
    end
    else if (mem_rd_valid && !mem_rvalid && cnt_q == lat)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= words.exists(mem_addr) ? words[mem_addr] : 32'h0;
      cnt_q      <= 2'h0;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      cnt_q      <= (mem_rd_valid && !mem_rvalid) ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule

// ===== bench/tb.sv
// self-checking bench: random table walks, abort reporting and status interrupt
`timescale 1ns/1ns
`include "ptw_regs.svh"
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, sn); end end
module tb;
  import ptw_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, req_valid, req_ready;
  logic        mem_rd_valid, mem_rvalid, rsp_valid, chk_done, chk_ok, xfer_valid;
  logic        abort_prefetch, abort_data, irq;
  logic [1:0]  htrans, lat;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_rdata, xfer_pa, pbase, sbase, seed;
  ptw_req_t    req;
  ptw_rsp_t    rsp;
  int          comparisons, miscompares;
  ptw_walker i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .req_valid(req_valid), .req(req), .req_ready(req_ready), .mem_rd_valid(mem_rd_valid),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .rsp_valid(rsp_valid), .rsp(rsp),
    .chk_done(chk_done), .chk_ok(chk_ok), .xfer_valid(xfer_valid), .xfer_pa(xfer_pa),
    .abort_prefetch(abort_prefetch), .abort_data(abort_data), .irq(irq));
  ptw_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .mem_rd_valid(mem_rd_valid), .mem_addr(mem_addr),
    .lat(lat), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // 50 ns clock
  always #25 hclk = ~hclk;
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // first-level address; n of zero always takes the process base
  function logic [31:0] l1a(logic [31:0] va, logic [2:0] n);
    logic [31:0] m;
    m = 32'hFFFF_FFFF >> n;
    if ((va & ~m) == 32'h0)
      return (pbase & ~(32'h0000_3FFF >> n)) | (((va & m) >> 18) & 32'hFFFF_FFFC);
    return (sbase & ~`PTW_L1_BASE_MASK) | ((va >> 18) & 32'hFFFF_FFFC);
  endfunction
  // page fields first, a section overrides them
  function ptw_rsp_t exp_rsp(logic [31:0] va, d1, d2, logic ins, fmt);
    ptw_rsp_t   r;
    logic [1:0] ix;
    r = '0;
    r.fault = d1[1:0] == 2'h0 || d1[1:0] == 2'h3 || (d1[1:0] == 2'h1 && d2[1:0] == 2'h0);
    ix = d2[1:0] == 2'h1 ? va[15:14] : va[11:10];
    r.subpage = !fmt && d2[11:4] != {4{d2[5:4]}};
    r.access_permission_pair = fmt ? d2[5:4] : d2[4 + 2 * ix +: 2];
    r.execute_never_flag = fmt & (d2[1:0] == 2'h1 ? d2[15] : d2[0]);
    r.size = d2[1:0] == 2'h1 ? PTW_SZ_LARGE : (fmt || d2[1:0] == 2'h3) ? PTW_SZ_EXT : PTW_SZ_SMALL;
    r.pa = d2[1:0] == 2'h1 ? {d2[31:16], va[15:0]} : {d2[31:12], va[11:0]};
    if (d1[1:0] == 2'h2)
    begin
      r.subpage = 1'b0;
      r.access_permission_pair = d1[11:10];
      r.execute_never_flag = fmt & d1[4];
      r.size = d1[18] ? PTW_SZ_SUPER : PTW_SZ_SECTION;
      r.pa = d1[18] ? {d1[31:24], va[23:0]} : {d1[31:20], va[19:0]};
    end
    return r;
  endfunction
  // single word transfer, address phase held until hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    `CHK("register", ex, v)
    `CHK("hresp", 1'b0, hresp)
  endtask
  // one walk; the checker answers only for good translations
  task automatic walk(input logic [31:0] va, input logic ins, input ptw_rsp_t e, input logic ok);
    int n;
    req_valid <= 1'b1;
    req <= '{va, ins};
    @(posedge hclk);
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(posedge hclk);
    if (n == 50)
      miscompares++;
    req_valid <= 1'b0;
    for (n = 0; n < 100 && rsp_valid !== 1'b1; n++) @(posedge hclk);
    if (n == 100)
      miscompares++;
    `CHK("fault", e.fault, rsp.fault)
    `CHK("prefetch abort", e.fault & ins, abort_prefetch)
    `CHK("data abort", e.fault & !ins, abort_data)
    `CHK("early transfer", 1'b0, xfer_valid)
    if (!e.fault)
    begin
      `CHK("pa", e.pa, rsp.pa)
      `CHK("size", e.size, rsp.size)
      `CHK("xn", e.execute_never_flag, rsp.execute_never_flag)
      `CHK("subpage", e.subpage, rsp.subpage)
      `CHK("ap", e.access_permission_pair, rsp.access_permission_pair)
      chk_done <= 1'b1;
      chk_ok <= ok;
      @(posedge hclk);
      `CHK("transfer", ok, xfer_valid)
      `CHK("transfer pa", e.pa, xfer_pa)
      chk_done <= 1'b0;
    end
  endtask
  task conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // cycles through every descriptor type with random fields, format and base selector
  initial
  begin
    logic [31:0] r, x, va, d1, d2;
    logic [2:0]  n, mk;
    logic        fmt, ins;
    ptw_rsp_t    e;
    hclk = 1'b0;
    hresetn = 1'b0;
    seed = 32'hE8EE;
    {hsel, hwrite, req_valid, chk_done, chk_ok, htrans, hsize, lat, haddr, hwdata, req} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`PTW_OFF_CTRL, `PTW_CTRL_RESET);
    rdc(`PTW_OFF_PROC_BASE, `PTW_BASE_RESET);
    rdc(`PTW_OFF_STATUS, 32'h0);
    rdc(8'h18, 32'h0);
    pbase = rnd();
    sbase = rnd();
    ahb(1'b1, `PTW_OFF_PROC_BASE, pbase, x);
    ahb(1'b1, `PTW_OFF_SYS_BASE, sbase, x);
    for (int i = 0; i < 64; i++)
    begin
      r = rnd();
      n = r[2:0];
      fmt = r[3];
      ins = r[4];
      mk = r[11:9];
      lat <= r[8:7];
      ahb(1'b1, `PTW_OFF_CTRL, {8'h0, fmt, 20'h0, n}, x);
      ahb(1'b1, `PTW_OFF_MASK, {29'h0, mk}, x);
      va = rnd();
      if (i % 2 == 0)
        va = va >> n;
      d1 = rnd();
      d2 = rnd();
      d1[1:0] = (i % 8 < 2) ? {i[0], i[0]} : (i % 8 < 4) ? 2'h2 : 2'h1;
      d1[18] = i[0];
      d2[1:0] = i[1:0];
      // equal pairs now and then, so whole pages are seen too
      if (i % 3 == 0)
        d2[11:4] = {4{d2[5:4]}};
      i_mem.words.delete();
      i_mem.words[l1a(va, n)] = d1;
      i_mem.words[{d1[31:10], va[19:12], 2'b00}] = d2;
      e = exp_rsp(va, d1, d2, ins, fmt);
      walk(va, ins, e, r[5] | r[6]);
      ahb(1'b0, `PTW_OFF_STATUS, 32'h0, x);
      `CHK("status", {e.fault & !ins, e.fault & ins, 1'b1}, x[2:0])
      `CHK("irq", |({e.fault & !ins, e.fault & ins, 1'b1} & mk), irq)
      if (!e.fault)
        rdc(`PTW_OFF_LAST_PA, e.pa);
      ahb(1'b1, `PTW_OFF_STATUS, 32'h7, x);
      rdc(`PTW_OFF_STATUS, 32'h0);
      `CHK("irq cleared", 1'b0, irq)
    end
    conclude();
  end
  // hang guard, far beyond the expected run length
  initial
  begin
    #(20000 * 50);
    miscompares++;
    conclude();
  end
endmodule
